// >>> hw/imd_pkg.sv
// Constants and types for the internal data memory decoder
package imd_pkg;
    localparam int IMD_RAM_BYTES = 256;
    localparam int IMD_XRAM_BYTES = 1024;
    localparam int IMD_USB_BYTES = 256;
    localparam int IMD_TOTAL_RAM = IMD_RAM_BYTES + IMD_XRAM_BYTES + IMD_USB_BYTES;
    localparam int IMD_FLASH_BYTES = 16384;
    localparam int IMD_SECTOR_BYTES = 512;
    localparam int IMD_SECTORS = IMD_FLASH_BYTES / IMD_SECTOR_BYTES;
    localparam logic [7:0] IMD_UPPER_BASE = 8'h80;
    localparam logic [7:0] IMD_BANK_END = 8'h1F;
    localparam logic [7:0] IMD_BIT_BASE = 8'h20;
    localparam logic [7:0] IMD_BIT_END = 8'h2F;
    localparam logic [7:0] IMD_RESET_BYTE = 8'h00;
    localparam logic [1:0] IMD_RESET_BANK = 2'h0;
    localparam logic [7:0] IMD_ERASED_BYTE = 8'hFF;
    localparam int IMD_ERASE_CYCLES = 4;
    localparam logic [8:0] IMD_SECTOR_LAST = 9'h1FF;

    typedef enum logic [1:0] {
        IMD_MODE_DIRECT = 2'h0,
        IMD_MODE_INDIRECT = 2'h1,
        IMD_MODE_REGISTER = 2'h2,
        IMD_MODE_BIT = 2'h3
    } imd_mode_type;

    typedef enum logic [1:0] {
        IMD_FL_IDLE = 2'b00,
        IMD_FL_ERASE = 2'b01,
        IMD_FL_DONE = 2'b11
    } imd_flash_state_type;
endpackage

// >>> hw/imd_decode.sv
// Internal data RAM, register banks, bit area and program flash decoder

// Operation
// - 256 byte RAM, upper half dual-mapped
// - Indirect upper access goes to RAM
// - Direct upper access goes to SFR space
// - Lower half same location either mode
// - Lowest 32 bytes are four register banks
// - Next 16 bytes byte or bit addressable
// - Program flash holds 16k bytes
// - Flash erased in 512 byte sectors in-system
// - Total RAM is 1536 bytes
module imd_decode (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Data access from core
    input wire logic data_req,
    input wire logic data_we,
    input wire imd_pkg::imd_mode_type data_mode,
    input wire logic [7:0] data_addr,
    input wire logic [7:0] data_wdata,
    input wire logic bit_wdata,
    input wire logic [1:0] bank_sel,
    output logic [7:0] data_rdata,
    output logic bit_rdata,
    output logic data_ack,
    // SFR space
    output logic sfr_req,
    output logic sfr_we,
    output logic [6:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Program flash
    input wire logic code_req,
    input wire logic [13:0] code_addr,
    output logic [7:0] code_rdata,
    input wire logic flash_we,
    input wire logic [13:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    input wire logic flash_erase,
    output logic flash_busy
);
    import imd_pkg::*;

    logic [7:0] ram [IMD_RAM_BYTES];
    logic [7:0] flash [IMD_FLASH_BYTES];
    imd_flash_state_type fl_state;
    logic [4:0] erase_sector;
    logic [8:0] erase_idx;
    function automatic logic [7:0] imd_target(input imd_mode_type m, input logic [7:0] a, input logic [1:0] b);
        case (m)
            IMD_MODE_REGISTER: imd_target = {3'h0, b, a[2:0]};
            IMD_MODE_BIT: imd_target = IMD_BIT_BASE + {4'h0, a[6:3]};
            default: imd_target = a;
        endcase
    endfunction

    // register operands land in selected bank
    wire [7:0] ram_index = imd_target(data_mode, data_addr, bank_sel);
    wire [2:0] bit_pos = data_addr[2:0];
    wire is_upper = data_addr >= IMD_UPPER_BASE;
    wire goes_sfr = data_req && data_mode == IMD_MODE_DIRECT && is_upper;
    // Indirect upper and all lower accesses go to RAM
    wire goes_ram = data_req && !goes_sfr;
    wire [7:0] cur_byte = ram[ram_index];
    wire [7:0] bit_mask = 8'h01 << bit_pos;
    wire [7:0] bit_merged = bit_wdata ? (cur_byte | bit_mask) : (cur_byte & ~bit_mask);
    wire [7:0] ram_wval = data_mode == IMD_MODE_BIT ? bit_merged : data_wdata;
    wire fl_idle = fl_state == IMD_FL_IDLE;
    // Flash bits only clear on write; erase restores ones
    wire [7:0] flash_merged = flash[flash_addr] & flash_wdata;
    wire [13:0] erase_addr = {erase_sector, erase_idx};

    always_ff @(posedge mclk) begin
        if (goes_ram && data_we) begin
            ram[ram_index] <= ram_wval;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            data_rdata <= IMD_RESET_BYTE;
            bit_rdata <= 1'b0;
            data_ack <= 1'b0;
        end else begin
            data_ack <= data_req;
            data_rdata <= goes_ram ? cur_byte : IMD_RESET_BYTE;
            bit_rdata <= goes_ram && data_mode == IMD_MODE_BIT ? cur_byte[bit_pos] : 1'b0;
        end
    end

    // SFR read data goes to the core straight from the SFR space
    // Direct upper reads therefore return zero on data_rdata
    // Limitation: sfr_rdata is not looked at inside this block
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sfr_req <= 1'b0;
            sfr_we <= 1'b0;
            sfr_addr <= 7'h00;
            sfr_wdata <= IMD_RESET_BYTE;
        end else begin
            sfr_req <= goes_sfr;
            sfr_we <= goes_sfr && data_we;
            sfr_addr <= data_addr[6:0];
            sfr_wdata <= data_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (fl_state == IMD_FL_ERASE) begin
            flash[erase_addr] <= IMD_ERASED_BYTE;
        end else if (fl_idle && flash_we) begin
            flash[flash_addr] <= flash_merged;
        end
    end

    // Erase walks one sector byte per cycle; core must wait on busy
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fl_state <= IMD_FL_IDLE;
            erase_sector <= 5'h00;
            erase_idx <= 9'h000;
            flash_busy <= 1'b0;
            code_rdata <= IMD_ERASED_BYTE;
        end else begin
            code_rdata <= code_req ? flash[code_addr] : code_rdata;
            case (fl_state)
                IMD_FL_IDLE: begin
                    if (flash_erase) begin
                        fl_state <= IMD_FL_ERASE;
                        erase_sector <= flash_addr[13:9];
                        erase_idx <= 9'h000;
                        flash_busy <= 1'b1;
                    end
                end
                IMD_FL_ERASE: begin
                    erase_idx <= erase_idx + 9'h001;
                    if (erase_idx == IMD_SECTOR_LAST) begin
                        fl_state <= IMD_FL_DONE;
                    end
                end
                IMD_FL_DONE: begin
                    fl_state <= IMD_FL_IDLE;
                    flash_busy <= 1'b0;
                end
                default: fl_state <= IMD_FL_IDLE;
            endcase
        end
    end

    property p_direct_upper_to_sfr;
        @(posedge mclk) disable iff (!resetn)
        (data_req && data_mode == IMD_MODE_DIRECT && data_addr[7]) |=> sfr_req && sfr_addr == $past(data_addr[6:0]);
    endproperty
    a_direct_upper_to_sfr: assert property (p_direct_upper_to_sfr) else $error("direct upper not sent to SFR");

    property p_indirect_no_sfr;
        @(posedge mclk) disable iff (!resetn)
        (data_req && data_mode == IMD_MODE_INDIRECT) |=> !sfr_req;
    endproperty
    a_indirect_no_sfr: assert property (p_indirect_no_sfr) else $error("indirect access reached SFR");

    property p_lower_direct_no_sfr;
        @(posedge mclk) disable iff (!resetn)
        (data_req && data_mode == IMD_MODE_DIRECT && !data_addr[7]) |=> !sfr_req;
    endproperty
    a_lower_direct_no_sfr: assert property (p_lower_direct_no_sfr) else $error("lower direct reached SFR");

    property p_direct_write;
        @(posedge mclk) disable iff (!resetn)
        (data_req && data_we && data_mode == IMD_MODE_DIRECT && data_addr[7]) |=> sfr_we && sfr_wdata == $past(data_wdata);
    endproperty
    a_direct_write: assert property (p_direct_write) else $error("direct upper write not passed on");

    property p_ram_no_sfr_write;
        @(posedge mclk) disable iff (!resetn)
        (data_req && data_mode != IMD_MODE_DIRECT) |=> !sfr_we;
    endproperty
    a_ram_no_sfr_write: assert property (p_ram_no_sfr_write) else $error("RAM access wrote SFR");

    property p_bank_index;
        @(posedge mclk) disable iff (!resetn)
        (data_mode == IMD_MODE_REGISTER) |-> ram_index == {3'h0, bank_sel, data_addr[2:0]} && ram_index <= IMD_BANK_END;
    endproperty
    a_bank_index: assert property (p_bank_index) else $error("register bank mapping wrong");

    property p_bit_index;
        @(posedge mclk) disable iff (!resetn)
        (data_mode == IMD_MODE_BIT) |-> ram_index >= IMD_BIT_BASE && ram_index <= IMD_BIT_END;
    endproperty
    a_bit_index: assert property (p_bit_index) else $error("bit address outside bit area");

    property p_erase_length;
        @(posedge mclk) disable iff (!resetn)
        $rose(flash_busy) |-> flash_busy [*8];
    endproperty
    a_erase_length: assert property (p_erase_length) else $error("erase ended too early");

    property p_erase_ends;
        @(posedge mclk) disable iff (!resetn)
        $rose(flash_busy) |-> ##[513:514] !flash_busy;
    endproperty
    a_erase_ends: assert property (p_erase_ends) else $error("erase not one sector long");

    property p_ack;
        @(posedge mclk) disable iff (!resetn)
        data_req |=> data_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("access not acknowledged");

    c_sfr: cover property (@(posedge mclk) disable iff (!resetn) goes_sfr);
    c_upper_ram: cover property (@(posedge mclk) disable iff (!resetn) goes_ram && is_upper);
    c_bit: cover property (@(posedge mclk) disable iff (!resetn) data_req && data_mode == IMD_MODE_BIT);
    c_erase: cover property (@(posedge mclk) disable iff (!resetn) $fell(flash_busy));
    c_register: cover property (@(posedge mclk) disable iff (!resetn) data_req && data_mode == IMD_MODE_REGISTER);
endmodule // imd_decode

// >>> tb/imd_sfr_model.sv
// Special function register space stand-in facing the decoder
module imd_sfr_model (
    // Clock
    input wire logic mclk,
    // Access from decoder
    input wire logic sfr_req,
    input wire logic [6:0] sfr_addr,
    output logic [7:0] sfr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] resp = 8'hA5;
    assign sfr_rdata = resp;
    // Toggles while unselected so stale data never looks valid
    always @(posedge mclk) begin
        resp <= sfr_req ? {1'b1, sfr_addr} : ~resp;
    end
endmodule // imd_sfr_model

// >>> tb/tb_internal_data_memory_decode.sv
// Self-checking bench for the internal data memory decoder
module tb_internal_data_memory_decode;
    timeunit 1ns;
    timeprecision 1ps;
    import imd_pkg::*;
    logic mclk = 0, resetn = 0, data_req = 0, data_we = 0, bit_wdata = 0;
    logic code_req = 0, flash_we = 0, flash_erase = 0;
    imd_mode_type data_mode = IMD_MODE_DIRECT;
    logic [7:0] data_addr = 0, data_wdata = 0, flash_wdata = 0, data_rdata, sfr_wdata, sfr_rdata, code_rdata;
    logic [1:0] bank_sel = 0;
    logic [13:0] code_addr = 0, flash_addr = 0;
    logic [6:0] sfr_addr;
    logic bit_rdata, data_ack, sfr_req, sfr_we, flash_busy;
    int err_total = 0, num_checks = 0;
    always #2 mclk = ~mclk;
    imd_decode dut (.mclk, .resetn, .data_req, .data_we, .data_mode, .data_addr, .data_wdata, .bit_wdata,
        .bank_sel, .data_rdata, .bit_rdata, .data_ack, .sfr_req, .sfr_we, .sfr_addr, .sfr_wdata, .sfr_rdata,
        .code_req, .code_addr, .code_rdata, .flash_we, .flash_addr, .flash_wdata, .flash_erase, .flash_busy);
    imd_sfr_model sfr (.mclk, .sfr_req, .sfr_addr, .sfr_rdata);
    task automatic wrap_up;
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    // One access; outputs are live on return
    task automatic acc(input logic we, input imd_mode_type m, input logic [7:0] a, wd, input logic bw);
        @(negedge mclk);
        {data_req, data_we} = {1'b1, we};
        data_mode = m;
        {data_addr, data_wdata, bit_wdata} = {a, wd, bw};
        @(negedge mclk);
        {data_req, data_we} = 2'b00;
        chk("ack", 8'h01, {7'h00, data_ack});
    endtask
    task automatic fetch(input logic [13:0] a, input logic [7:0] exp);
        @(negedge mclk);
        {code_req, code_addr} = {1'b1, a};
        @(negedge mclk);
        code_req = 0;
        chk("code", exp, code_rdata);
    endtask
    task automatic sc_dual;
        acc(1, IMD_MODE_INDIRECT, 8'h90, 8'hA5, 0);
        acc(1, IMD_MODE_DIRECT, 8'h90, 8'h3C, 0);
        chk("sfr_req", 8'h01, {7'h00, sfr_req});
        chk("sfr_we", 8'h01, {7'h00, sfr_we});
        chk("sfr_addr", 8'h10, {1'b0, sfr_addr});
        chk("sfr_wdata", 8'h3C, sfr_wdata);
        acc(0, IMD_MODE_DIRECT, 8'h90, 8'h00, 0);
        chk("dir_rd", 8'h00, data_rdata);
        acc(0, IMD_MODE_INDIRECT, 8'h90, 8'h00, 0);
        chk("ind_rd", 8'hA5, data_rdata);
        chk("no_sfr", 8'h00, {7'h00, sfr_req});
    endtask
    task automatic sc_lower;
        acc(1, IMD_MODE_DIRECT, 8'h7F, 8'hE1, 0);
        chk("lo_sfr", 8'h00, {7'h00, sfr_req});
        acc(0, IMD_MODE_INDIRECT, 8'h7F, 8'h00, 0);
        chk("lo_rd", 8'hE1, data_rdata);
    endtask
    task automatic sc_bank;
        for (int b = 0; b < 4; b++) begin
            bank_sel = b[1:0];
            acc(1, IMD_MODE_REGISTER, 8'h07, 8'h70 | b[7:0], 0);
        end
        for (int b = 0; b < 4; b++) begin
            acc(0, IMD_MODE_INDIRECT, 8'h07 + 8'(b * 8), 8'h00, 0);
            chk("bank", 8'h70 | b[7:0], data_rdata);
        end
    endtask
    task automatic sc_bit;
        acc(1, IMD_MODE_INDIRECT, 8'h21, 8'h00, 0);
        acc(1, IMD_MODE_INDIRECT, 8'h2F, 8'hFF, 0);
        acc(1, IMD_MODE_BIT, 8'h0D, 8'h00, 1);
        acc(1, IMD_MODE_BIT, 8'h7F, 8'h00, 0);
        acc(0, IMD_MODE_INDIRECT, 8'h21, 8'h00, 0);
        chk("bit_lo", 8'h20, data_rdata);
        acc(0, IMD_MODE_INDIRECT, 8'h2F, 8'h00, 0);
        chk("bit_hi", 8'h7F, data_rdata);
        acc(0, IMD_MODE_BIT, 8'h0D, 8'h00, 0);
        chk("bit_rd", 8'h01, {7'h00, bit_rdata});
    endtask
    // Reset values, then reset dropped in the middle of an erase
    task automatic sc_reset;
        chk("rst_ack", 8'h00, {7'h00, data_ack});
        chk("rst_sfr", 8'h00, {7'h00, sfr_req});
        chk("rst_rd", 8'h00, data_rdata);
        chk("rst_code", IMD_ERASED_BYTE, code_rdata);
        @(negedge mclk);
        {flash_erase, flash_addr} = {1'b1, 14'h0000};
        @(negedge mclk);
        flash_erase = 0;
        repeat (10) @(negedge mclk);
        chk("mid_busy", 8'h01, {7'h00, flash_busy});
        resetn = 0;
        @(negedge mclk);
        chk("rst_busy", 8'h00, {7'h00, flash_busy});
        chk("rst_code2", IMD_ERASED_BYTE, code_rdata);
        resetn = 1;
        fetch(14'h0000, IMD_ERASED_BYTE);
    endtask
    // Last sector so the top of the 16k range is reached
    task automatic sc_flash;
        int n;
        @(negedge mclk);
        {flash_erase, flash_addr} = {1'b1, 14'h3E05};
        @(negedge mclk);
        flash_erase = 0;
        chk("busy", 8'h01, {7'h00, flash_busy});
        n = 0;
        while (flash_busy !== 1'b0 && n < 600) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 600) begin
            err_total++;
            wrap_up();
        end
        {flash_we, flash_wdata} = {1'b1, 8'h5A};
        @(negedge mclk);
        flash_we = 0;
        fetch(14'h3E05, 8'h5A);
        fetch(14'h3FFF, IMD_ERASED_BYTE);
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        resetn = 1;
        sc_reset();
        sc_dual();
        sc_lower();
        sc_bank();
        sc_bit();
        sc_flash();
        wrap_up();
    end
endmodule // tb_internal_data_memory_decode
